// ===== hdl/i2ccd_ctrl.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module i2ccd_ctrl (
    input wire logic SYS_CLK, // 20 MHz module clock
    input wire logic RST, // async reset, active high
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [i2ccd_pkg::ADDR_W-1:0] S_AXI_AWADDR, // write byte address
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // byte enables
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    output logic [1:0] S_AXI_BRESP, // write response
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    input wire logic [i2ccd_pkg::ADDR_W-1:0] S_AXI_ARADDR, // read byte address
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    input wire logic SCL_I, // scl line level
    output logic SCL_O, // scl drive value, always low
    output logic SCL_OE, // pull scl low
    input wire logic SDA_I, // sda line level
    output logic SDA_O, // sda drive value, always low
    output logic SDA_OE, // pull sda low
    input wire logic START_SEEN, // pulse: start detected on bus
    input wire logic BYTE_DONE, // pulse: ninth clock falling edge
    input wire logic ADDR_MATCH, // pulse: own address matched
    input wire logic ARB_LOST, // pulse: arbitration lost
    input wire logic SLAVE_RW_IN, // calling address rw bit
    output logic IRQ, // interrupt request
    output logic SCL_TICK, // pulse each scl half period in master
    output i2ccd_pkg::i2ccd_timing_s TIMING, // counts for current code
    output logic MODULE_RESET, // interface held in reset
    output logic MASTER_MODE, // master select in effect
    output logic TX_MODE // direction: 1 transmit
);
    logic [7:0] ctl_r, ctl_nxt, code_r, code_nxt;
    logic flag_r, flag_nxt, srw_r, srw_nxt, armed_r, armed_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] status, rd_byte;
    logic en, ms_eff, wr_go, rd_go, flag_set, flag_clr, rd_hit;
    i2ccd_pkg::i2ccd_state_e state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt, tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt, scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
    i2ccd_pkg::i2ccd_timing_s timing_r, timing_nxt;

    assign en = ctl_r[i2ccd_pkg::CTL_ON];
    assign ms_eff = en & ctl_r[i2ccd_pkg::CTL_MS];
    // write needs address and data together; both handshake on the same edge
    assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_r;
    assign rd_go = S_AXI_ARVALID & ~rvalid_r;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;
    assign S_AXI_ARREADY = ~rvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    // slave events count only once a fresh start has been seen
    assign flag_set = en & (ARB_LOST | (BYTE_DONE & (ms_eff | armed_r)) | (ADDR_MATCH & armed_r));
    assign flag_clr = wr_go & (S_AXI_AWADDR == i2ccd_pkg::ADDR_STATUS) & S_AXI_WSTRB[0]
                      & S_AXI_WDATA[i2ccd_pkg::ST_IRQF];
    assign status = {SCL_I, SDA_I, state_r != i2ccd_pkg::S_IDLE, 2'h0, srw_r, flag_r, 1'h0};

    always_comb begin
        rd_hit = 1'b1;
        case (S_AXI_ARADDR)
            i2ccd_pkg::ADDR_PRESCALE: rd_byte = code_r;
            i2ccd_pkg::ADDR_CONTROL: rd_byte = ctl_r & i2ccd_pkg::CTL_RD_MASK;
            i2ccd_pkg::ADDR_STATUS: rd_byte = status;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        ctl_nxt = ctl_r;
        code_nxt = code_r;
        bvalid_nxt = bvalid_r & ~S_AXI_BREADY;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r & ~S_AXI_RREADY;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = i2ccd_pkg::RESP_OKAY;
            case (S_AXI_AWADDR)
                i2ccd_pkg::ADDR_PRESCALE: if (S_AXI_WSTRB[0]) code_nxt = S_AXI_WDATA[7:0];
                i2ccd_pkg::ADDR_CONTROL: if (S_AXI_WSTRB[0]) ctl_nxt = S_AXI_WDATA[7:0];
                i2ccd_pkg::ADDR_STATUS: ;
                default: bresp_nxt = i2ccd_pkg::RESP_SLVERR;
            endcase
        end
        // losing arbitration drops master select; the fsm skips the stop
        if (en & ARB_LOST & ctl_r[i2ccd_pkg::CTL_MS]) begin
            ctl_nxt[i2ccd_pkg::CTL_MS] = 1'b0;
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = {24'h000000, rd_byte};
            rresp_nxt = rd_hit ? i2ccd_pkg::RESP_OKAY : i2ccd_pkg::RESP_SLVERR;
        end
        // set beats a simultaneous write-one clear
        flag_nxt = en & (flag_set | (flag_r & ~flag_clr));
        armed_nxt = en & (armed_r | START_SEEN);
        srw_nxt = (en & ADDR_MATCH & armed_r) ? SLAVE_RW_IN : srw_r & en;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctl_r <= i2ccd_pkg::CTL_RESET;
            code_r <= i2ccd_pkg::PRESCALE_RESET;
            flag_r <= 1'b0;
            srw_r <= 1'b0;
            armed_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= i2ccd_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= i2ccd_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            ctl_r <= ctl_nxt;
            code_r <= code_nxt;
            flag_r <= flag_nxt;
            srw_r <= srw_nxt;
            armed_r <= armed_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // line sequencer: start and stop with tabulated holds
    always_comb begin
        timing_nxt = i2ccd_pkg::i2ccd_lookup(code_r);
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
        case (state_r)
            // no bus-busy check here; a clash surfaces as arbitration loss
            i2ccd_pkg::S_IDLE: if (ms_eff) begin
                state_nxt = i2ccd_pkg::S_START_SDA;
                cnt_nxt = timing_r.start_hold - 16'h0001;
            end
            i2ccd_pkg::S_START_SDA: if (cnt_r == 16'h0000) begin
                state_nxt = i2ccd_pkg::S_START_SCL;
                cnt_nxt = timing_r.sda_hold - 16'h0001;
            end
            i2ccd_pkg::S_START_SCL: if (cnt_r == 16'h0000) state_nxt = i2ccd_pkg::S_MASTER;
            i2ccd_pkg::S_MASTER: if (!ms_eff) begin
                state_nxt = i2ccd_pkg::S_STOP_SCL;
                cnt_nxt = timing_r.stop_hold - 16'h0001;
            end
            i2ccd_pkg::S_STOP_SCL: begin
                // a slave stretching scl delays the stop hold
                if (!SCL_I) cnt_nxt = cnt_r;
                if (SCL_I && cnt_r == 16'h0000) begin
                    state_nxt = i2ccd_pkg::S_STOP_SDA;
                    cnt_nxt = timing_r.sda_hold - 16'h0001;
                end
            end
            i2ccd_pkg::S_STOP_SDA: if (cnt_r == 16'h0000) state_nxt = i2ccd_pkg::S_IDLE;
            default: state_nxt = i2ccd_pkg::S_IDLE;
        endcase
        if (ARB_LOST && state_r != i2ccd_pkg::S_STOP_SCL && state_r != i2ccd_pkg::S_STOP_SDA) begin
            state_nxt = i2ccd_pkg::S_IDLE;
        end
        if (!en) begin
            state_nxt = i2ccd_pkg::S_IDLE;
            cnt_nxt = 16'h0000;
        end
        scl_oe_nxt = (state_nxt == i2ccd_pkg::S_START_SCL) || (state_nxt == i2ccd_pkg::S_MASTER);
        sda_oe_nxt = (state_nxt != i2ccd_pkg::S_IDLE) && (state_nxt != i2ccd_pkg::S_STOP_SDA);
        tick_nxt = 1'b0;
        tick_cnt_nxt = timing_r.scl_div[15:1] - 16'h0001;
        if (state_r == i2ccd_pkg::S_MASTER && state_nxt == i2ccd_pkg::S_MASTER) begin
            tick_cnt_nxt = tick_cnt_r - 16'h0001;
            if (tick_cnt_r == 16'h0000) begin
                tick_nxt = 1'b1;
                tick_cnt_nxt = timing_r.scl_div[15:1] - 16'h0001;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_r <= i2ccd_pkg::S_IDLE;
            cnt_r <= 16'h0000;
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            timing_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            timing_r <= timing_nxt;
        end
    end

    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = scl_oe_r;
    assign SDA_OE = sda_oe_r;
    assign SCL_TICK = tick_r;
    assign TIMING = timing_r;
    assign MODULE_RESET = ~en;
    assign MASTER_MODE = ms_eff;
    assign TX_MODE = en & ctl_r[i2ccd_pkg::CTL_TX];
    assign IRQ = en & ctl_r[i2ccd_pkg::CTL_IRQ] & flag_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_start_entry;
        sda_oe_r && !scl_oe_r && state_r == i2ccd_pkg::S_START_SDA;
    endsequence
    sequence s_stop_entry;
        sda_oe_r && !scl_oe_r && state_r == i2ccd_pkg::S_STOP_SCL;
    endsequence

    a_irq_masked: assert property (!ctl_r[i2ccd_pkg::CTL_IRQ] |-> !IRQ)
        else $error("irq raised while masked");
    a_irq_raised: assert property (en && ctl_r[i2ccd_pkg::CTL_IRQ] && flag_r |-> IRQ)
        else $error("irq missing with flag set");
    a_flag_kept: assert property (en && flag_r && !flag_clr |=> flag_r)
        else $error("pending flag lost");
    a_start_drive: assert property (state_r == i2ccd_pkg::S_IDLE && ms_eff && !ARB_LOST |=> s_start_entry
        ##0 cnt_r == timing_r.start_hold - 16'h0001)
        else $error("start not driven");
    a_stop_drive: assert property (state_r == i2ccd_pkg::S_MASTER && !ms_eff && en && !ARB_LOST
        |=> s_stop_entry)
        else $error("stop not driven");
    a_arb_nostop: assert property (en && ARB_LOST && state_r == i2ccd_pkg::S_MASTER
        |=> !sda_oe_r && !scl_oe_r && !ctl_r[i2ccd_pkg::CTL_MS])
        else $error("stop after arbitration loss");
    a_disabled_idle: assert property (!en |=> state_r == i2ccd_pkg::S_IDLE && !flag_r && !armed_r)
        else $error("interface active while disabled");
    a_slave_ignore: assert property (!armed_r && !flag_r && !ARB_LOST && !ms_eff && !START_SEEN
        |=> !flag_r ##1 (!flag_r || $past(ARB_LOST || ms_eff)))
        else $error("slave event before start");
    a_code_83: assert property (code_r == 8'h83 && $stable(code_r) |-> timing_r.scl_div == 16'h0068
        && timing_r.sda_hold == 16'h0020 && timing_r.start_hold == 16'h0024
        && timing_r.stop_hold == 16'h0038)
        else $error("code 83 counts wrong");
    a_code_bf: assert property (code_r == 8'hBF && $stable(code_r) |-> timing_r.scl_div == 16'h3C00)
        else $error("code bf divider wrong");
endmodule // i2ccd_ctrl

// ===== hdl/i2ccd_pkg.sv
// How it works
// - prescale code maps to SCL period in clocks; 83 gives 104, BF gives 15360
// - each code also gives SDA hold, START hold and STOP hold counts
// - enable bit low holds the interface in reset; registers stay accessible
// - all other control bits have no effect until enable bit is high
// - slave logic enabled mid-transfer waits for the next START before acting
// - master logic has no busy knowledge; arbitration loss resolves a clash
// - interrupt enable low blocks the request but keeps pending flag set
// - interrupt enable high raises request whenever the transfer flag is set
// - master-select bit resets to zero, meaning slave mode
// - master-select rising drives a START and enters master mode
// - master-select falling drives a STOP and returns to slave mode
// - arbitration loss clears master-select with no STOP driven
// - direction bit: zero receive, one transmit, for master and slave
// - control register readable and writable at any time in any mode
// - transfer flag sets on arbitration loss, byte done, address match; write one clears
// - slave rw flag reports calling address direction: 0 write, 1 read
package i2ccd_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int CTL_ON = 7;
    localparam int CTL_IRQ = 6;
    localparam int CTL_MS = 5;
    localparam int CTL_TX = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_RD_MASK = 8'hF9;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam int ST_IRQF = 1;
    localparam int ST_SRW = 2;
    localparam int ST_MASTER = 5;
    localparam int ST_SDA_LVL = 6;
    localparam int ST_SCL_LVL = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] DIV_EXTRA = 16'h0002;
    localparam logic [15:0] HOLD_EXTRA = 16'h0003;
    localparam logic [15:0] MUL_TAB [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004};
    localparam logic [15:0] SCL2TAP [8] = '{16'h0004, 16'h0004, 16'h0006, 16'h0006,
                                           16'h000E, 16'h001E, 16'h003E, 16'h007E};
    localparam logic [15:0] TAP2TAP [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
                                           16'h0010, 16'h0020, 16'h0040, 16'h0080};
    localparam logic [15:0] SCL_TAP [8] = '{16'h0005, 16'h0006, 16'h0007, 16'h0008,
                                           16'h0009, 16'h000A, 16'h000C, 16'h000F};
    localparam logic [15:0] SDA_TAP [8] = '{16'h0001, 16'h0001, 16'h0002, 16'h0002,
                                           16'h0003, 16'h0003, 16'h0004, 16'h0004};
    localparam logic [15:0] START_K [8] = '{16'h0002, 16'h0002, 16'h0002, 16'h0006,
                                           16'h000E, 16'h001E, 16'h003E, 16'h007E};

    typedef struct packed {
        logic [15:0] scl_div;
        logic [15:0] sda_hold;
        logic [15:0] start_hold;
        logic [15:0] stop_hold;
    } i2ccd_timing_s;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_START_SDA = 3'h1,
        S_START_SCL = 3'h3,
        S_MASTER = 3'h2,
        S_STOP_SCL = 3'h6,
        S_STOP_SDA = 3'h7
    } i2ccd_state_e;

    // code fields: [7:6] multiplier, [5:3] tap row, [2:0] tap column
    function automatic i2ccd_timing_s i2ccd_lookup(input logic [7:0] code);
        logic [15:0] m;
        logic [15:0] s;
        logic [15:0] t;
        logic [15:0] c1;
        i2ccd_timing_s r;
        m = MUL_TAB[code[7:6]];
        s = SCL2TAP[code[5:3]];
        t = TAP2TAP[code[5:3]];
        c1 = 16'((SCL_TAP[code[2:0]] - 16'h0001) * t);
        r.scl_div = 16'(m * 16'h0002 * (s + c1 + DIV_EXTRA));
        r.sda_hold = 16'(m * (s + 16'((SDA_TAP[code[2:0]] - 16'h0001) * t) + HOLD_EXTRA));
        r.start_hold = 16'(m * (c1 + START_K[code[5:3]]));
        r.stop_hold = 16'(m * (c1 + s + HOLD_EXTRA));
        return r;
    endfunction
endpackage

// ===== test/i2ccd_bus_model.sv
`timescale 1ns/1ps
module i2ccd_bus_model (
    input wire logic clk, // module clock
    input wire logic dut_scl_oe, // design pulls scl low
    input wire logic dut_sda_oe, // design pulls sda low
    output logic scl, // wired-and scl level
    output logic sda, // wired-and sda level
    output logic start_seen // pulse on start condition
);
    logic scl_low_r = 1'b0;
    logic sda_low_r = 1'b0;
    logic sda_q = 1'b1;
    // pull-ups: a released line floats high
    assign scl = ~(dut_scl_oe | scl_low_r);
    assign sda = ~(dut_sda_oe | sda_low_r);
    initial start_seen = 1'b0;
    always @(posedge clk) begin
        sda_q <= sda;
        start_seen <= sda_q & ~sda & scl;
    end
    // clock stretching by another device on the bus
    task automatic stretch_scl(input int n);
        @(posedge clk);
        scl_low_r <= 1'b1;
        repeat (n) @(posedge clk);
        scl_low_r <= 1'b0;
    endtask
    // another master opens a frame; sda released before scl to avoid a stop
    task automatic start_cond();
        @(posedge clk);
        sda_low_r <= 1'b1;
        repeat (4) @(posedge clk);
        scl_low_r <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low_r <= 1'b0;
        @(posedge clk);
        scl_low_r <= 1'b0;
    endtask
endmodule // i2ccd_bus_model

// ===== test/i2c_ctrl_and_clock_divider_tb.sv
`timescale 1ns/1ps
module i2c_ctrl_and_clock_divider_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic byte_done = 1'b0, addr_match = 1'b0, arb_lost = 1'b0, rw_in = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, tick, mod_rst, mst, txm;
    logic scl_oe, sda_oe, scl_o, sda_o, scl, sda, start_seen;
    logic [1:0] bresp, rresp;
    i2ccd_pkg::i2ccd_timing_s timing;
    int error_cnt = 0, check_count = 0, tick_cnt = 0, start_cnt = 0, stop_cnt = 0, n0;
    localparam logic [7:0] CODES [2] = '{8'hBF, 8'h83};
    localparam i2ccd_pkg::i2ccd_timing_s EXP_T [2] = '{'{16'h3C00, 16'h0804, 16'h1DF8, 16'h1E04},
                                                      '{16'h0068, 16'h0020, 16'h0024, 16'h0038}};

    initial forever #25 clk = ~clk;
    // start and stop phases told apart by the master flag
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + int'(tick === 1'b1);
        start_cnt <= start_cnt + int'(sda_oe === 1'b1 && scl_oe === 1'b0 && mst === 1'b1);
        stop_cnt <= stop_cnt + int'(sda_oe === 1'b1 && scl_oe === 1'b0 && mst === 1'b0);
    end

    i2ccd_ctrl i_dut (.SYS_CLK(clk), .RST(rst), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .SCL_I(scl), .SCL_O(scl_o),
        .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .START_SEEN(start_seen),
        .BYTE_DONE(byte_done), .ADDR_MATCH(addr_match), .ARB_LOST(arb_lost), .SLAVE_RW_IN(rw_in),
        .IRQ(irq), .SCL_TICK(tick), .TIMING(timing), .MODULE_RESET(mod_rst), .MASTER_MODE(mst),
        .TX_MODE(txm));
    i2ccd_bus_model i_bus (.clk(clk), .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda),
        .start_seen(start_seen));

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d of %0d checks", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        // each channel is released at its own handshake edge
        while (aw_left || w_left) begin
            @(posedge clk);
            if (aw_left && awready === 1'b1) begin
                aw_left = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_left && wready === 1'b1) begin
                w_left = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 1'b0;
    endtask
    task automatic wait_scl_low();
        do @(posedge clk); while (scl_oe !== 1'b1);
    endtask
    task automatic t_reset();
        rdr(i2ccd_pkg::ADDR_CONTROL);
        chk("control reset", 64'(rd), 64'h0);
        rdr(i2ccd_pkg::ADDR_PRESCALE);
        chk("prescale reset", 64'(rd), 64'h0);
        chk("module reset", 64'(mod_rst), 64'h1);
        rdr(8'h0C);
        chk("unmapped resp", 64'(rresp), 64'(i2ccd_pkg::RESP_SLVERR));
        chk("unmapped data", 64'(rd), 64'h0);
        wr(8'h0C, 32'hFF);
        chk("unmapped wr resp", 64'(bresp), 64'(i2ccd_pkg::RESP_SLVERR));
        chk("line drive", 64'({scl_o, sda_o}), 64'h0);
    endtask
    task automatic t_disabled();
        wr(i2ccd_pkg::ADDR_CONTROL, 32'h30);
        repeat (4) @(posedge clk);
        chk("gated modes", 64'({mst, txm, sda_oe}), 64'h0);
        rdr(i2ccd_pkg::ADDR_CONTROL);
        chk("control readback", 64'(rd), 64'h30);
        chk("okay resps", 64'({bresp, rresp}), 64'h0);
    endtask
    task automatic t_timing();
        for (int i = 0; i < 2; i++) begin
            wr(i2ccd_pkg::ADDR_PRESCALE, 32'(CODES[i]));
            repeat (2) @(posedge clk);
            chk("timing", timing, EXP_T[i]);
        end
    endtask
    task automatic t_master();
        n0 = start_cnt;
        wr(i2ccd_pkg::ADDR_CONTROL, 32'hB0);
        wait_scl_low();
        chk("start hold", 64'(start_cnt - n0), 64'd36);
        repeat (40) @(posedge clk);
        n0 = tick_cnt;
        repeat (520) @(posedge clk);
        chk("scl ticks", 64'(tick_cnt - n0), 64'd10);
        chk("master tx", 64'({mst, txm}), 64'h3);
        @(posedge clk) byte_done <= 1'b1;
        @(posedge clk) byte_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq masked", 64'(irq), 64'h0);
        rdr(i2ccd_pkg::ADDR_STATUS);
        chk("flag pending", 64'(rd[i2ccd_pkg::ST_IRQF]), 64'h1);
        wr(i2ccd_pkg::ADDR_CONTROL, 32'hF0);
        chk("irq on", 64'(irq), 64'h1);
        n0 = stop_cnt;
        wr(i2ccd_pkg::ADDR_CONTROL, 32'hD0);
        i_bus.stretch_scl(10);
        do @(posedge clk); while (sda_oe !== 1'b0);
        chk("stop hold", 64'(stop_cnt - n0), 64'd66);
        chk("slave mode", 64'(mst), 64'h0);
        wr(i2ccd_pkg::ADDR_STATUS, 32'h2);
        chk("irq cleared", 64'(irq), 64'h0);
    endtask
    task automatic t_arb();
        n0 = stop_cnt;
        wr(i2ccd_pkg::ADDR_CONTROL, 32'hB0);
        wait_scl_low();
        // let the start finish so the loss hits the master hold state
        repeat (40) @(posedge clk);
        @(posedge clk) arb_lost <= 1'b1;
        @(posedge clk) arb_lost <= 1'b0;
        repeat (2) @(posedge clk);
        chk("arb released", 64'({mst, scl_oe, sda_oe}), 64'h0);
        chk("no stop", 64'(stop_cnt - n0), 64'h0);
        rdr(i2ccd_pkg::ADDR_CONTROL);
        chk("ms cleared", 64'(rd), 64'h90);
        rdr(i2ccd_pkg::ADDR_STATUS);
        chk("arb flag", 64'(rd[i2ccd_pkg::ST_IRQF]), 64'h1);
        wr(i2ccd_pkg::ADDR_STATUS, 32'h2);
    endtask
    task automatic match();
        @(posedge clk) addr_match <= 1'b1;
        @(posedge clk) addr_match <= 1'b0;
        rdr(i2ccd_pkg::ADDR_STATUS);
    endtask
    task automatic t_slave();
        wr(i2ccd_pkg::ADDR_CONTROL, 32'h00);
        wr(i2ccd_pkg::ADDR_CONTROL, 32'h80);
        chk("slave rx", 64'(txm), 64'h0);
        rw_in <= 1'b1;
        match();
        chk("unarmed match", 64'(rd[i2ccd_pkg::ST_IRQF]), 64'h0);
        i_bus.start_cond();
        match();
        chk("match flags", 64'({rd[i2ccd_pkg::ST_SRW], rd[i2ccd_pkg::ST_IRQF]}), 64'h3);
        wr(i2ccd_pkg::ADDR_CONTROL, 32'h90);
        chk("slave tx", 64'(txm), 64'h1);
        wr(i2ccd_pkg::ADDR_CONTROL, 32'h10);
        rdr(i2ccd_pkg::ADDR_STATUS);
        chk("soft reset", 64'(rd[i2ccd_pkg::ST_IRQF]), 64'h0);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_disabled();
        t_timing();
        t_master();
        t_arb();
        t_slave();
        summarize();
    end
endmodule // i2c_ctrl_and_clock_divider_tb
